// >>> core/kwu_ports.sv
// Key wakeup logic for general-purpose ports D and H
//
// Added by the designer: the strobed register port and the register offsets.
`timescale 1ns/10ps

module kwu_ports
    import kwu_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [KWU_ADDR_W-1:0] regAddr,
    input wire logic [KWU_DATA_W-1:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [KWU_DATA_W-1:0] regRdata,
    input wire logic [WIDTH-1:0] portDIn,
    output logic [WIDTH-1:0] portDOut,
    output logic [WIDTH-1:0] portDOe,
    input wire logic [WIDTH-1:0] portHIn,
    output logic [WIDTH-1:0] portHOut,
    output logic [WIDTH-1:0] portHOe,
    input wire logic wideExpandedMode,
    input wire logic specialNarrowMode,
    input wire logic stopMode,
    output logic portDIrq,
    output logic portHIrq,
    output logic wakeIrq,
    output logic stopWake
);

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [WIDTH-1:0] portDData;
    logic [WIDTH-1:0] portDDir;
    logic [WIDTH-1:0] portDEnable;
    logic [WIDTH-1:0] portDFlags;
    logic [WIDTH-1:0] portHData;
    logic [WIDTH-1:0] portHDir;
    logic [WIDTH-1:0] portHEnable;
    logic [WIDTH-1:0] portHFlags;
    logic extIntEnable;
    logic extBusMode;
    logic [WIDTH-1:0] portDLast;
    logic [WIDTH-1:0] portHLast;
    logic [WIDTH-1:0] portDFall;
    logic [WIDTH-1:0] portHFall;
    logic portDMapped;
    logic [KWU_DATA_W-1:0] next_regRdata;
    logic [WIDTH-1:0] next_portDFlags;
    logic [WIDTH-1:0] next_portHFlags;
    logic next_portDIrq;
    logic next_portHIrq;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Write strobe for one register offset
    function automatic logic hit(
        input logic [KWU_ADDR_W-1:0] addr,
        input logic [KWU_ADDR_W-1:0] target,
        input logic strobe
    );
        hit = strobe && (addr == target);
    endfunction

    // Sticky flag update; a new edge beats a clear in the same cycle
    function automatic logic [WIDTH-1:0] flagUpdate(
        input logic [WIDTH-1:0] flags,
        input logic [WIDTH-1:0] edges,
        input logic clear,
        input logic [WIDTH-1:0] wdata
    );
        logic [WIDTH-1:0] kept;
        kept = clear ? (flags & ~wdata) : flags;
        flagUpdate = kept | edges;
    endfunction

    // Pin value as software sees it
    function automatic logic [WIDTH-1:0] pinView(
        input logic [WIDTH-1:0] dir,
        input logic [WIDTH-1:0] latch,
        input logic [WIDTH-1:0] pins
    );
        pinView = (dir & latch) | (~dir & pins);
    endfunction

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    // Port D pins serve as the external data bus in these modes
    always_comb begin
        portDMapped = 1'b1;
        if (wideExpandedMode) begin
            portDMapped = 1'b0;
        end else if (specialNarrowMode && extBusMode) begin
            portDMapped = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Edge detection
    // ------------------------------------------------------------
    // Raw pins are sampled regardless of direction, so an output
    // driven low by software also raises its flag.
    // One history flop per pin; driven outputs feed back through the pad
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            portDLast <= KWU_PIN_HISTORY_RESET;
        end else begin
            portDLast <= portDIn;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            portHLast <= KWU_PIN_HISTORY_RESET;
        end else begin
            portHLast <= portHIn;
        end
    end

    // History resets low so a pin held low at reset sets no flag
    assign portDFall = portDLast & ~portDIn;
    assign portHFall = portHLast & ~portHIn;

    // ------------------------------------------------------------
    // Port D registers
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            portDData <= KWU_DATA_RESET;
        end else if (portDMapped &&
                     hit(regAddr, KWU_PORT_D_PIN_DATA, regWrite)) begin
            portDData <= regWdata[WIDTH-1:0];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            portDDir <= KWU_DIR_RESET;
        end else if (portDMapped &&
                     hit(regAddr, KWU_PORT_D_DIRECTION, regWrite)) begin
            portDDir <= regWdata[WIDTH-1:0];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            portDEnable <= KWU_ENABLE_RESET;
        end else if (portDMapped &&
                     hit(regAddr, KWU_PORT_D_WAKE_ENABLE, regWrite)) begin
            portDEnable <= regWdata[WIDTH-1:0];
        end
    end

    always_comb begin
        next_portDFlags = flagUpdate(
            portDFlags,
            portDFall,
            portDMapped && hit(regAddr, KWU_PORT_D_WAKE_FLAGS, regWrite),
            regWdata[WIDTH-1:0]
        );
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            portDFlags <= KWU_FLAGS_RESET;
        end else begin
            portDFlags <= next_portDFlags;
        end
    end

    // ------------------------------------------------------------
    // Port H registers
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            portHData <= KWU_DATA_RESET;
        end else if (hit(regAddr, KWU_PORT_H_PIN_DATA, regWrite)) begin
            portHData <= regWdata[WIDTH-1:0];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            portHDir <= KWU_DIR_RESET;
        end else if (hit(regAddr, KWU_PORT_H_DIRECTION, regWrite)) begin
            portHDir <= regWdata[WIDTH-1:0];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            portHEnable <= KWU_ENABLE_RESET;
        end else if (hit(regAddr, KWU_PORT_H_WAKE_ENABLE, regWrite)) begin
            portHEnable <= regWdata[WIDTH-1:0];
        end
    end

    always_comb begin
        next_portHFlags = flagUpdate(
            portHFlags,
            portHFall,
            hit(regAddr, KWU_PORT_H_WAKE_FLAGS, regWrite),
            regWdata[WIDTH-1:0]
        );
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            portHFlags <= KWU_FLAGS_RESET;
        end else begin
            portHFlags <= next_portHFlags;
        end
    end

    // ------------------------------------------------------------
    // Wake control register
    // ------------------------------------------------------------
    // The bus mode bit only matters in special narrow mode
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            extIntEnable <= KWU_CONTROL_RESET[KWU_EXT_INT_EN_BIT];
        end else if (hit(regAddr, KWU_WAKE_CONTROL, regWrite)) begin
            extIntEnable <= regWdata[KWU_EXT_INT_EN_BIT];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            extBusMode <= KWU_CONTROL_RESET[KWU_EXT_BUS_MODE_BIT];
        end else if (hit(regAddr, KWU_WAKE_CONTROL, regWrite)) begin
            extBusMode <= regWdata[KWU_EXT_BUS_MODE_BIT];
        end
    end

    // ------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------
    // While port D carries the external bus its GPIO drivers are off
    // Each pin driver is its own flop; outputs lag the registers a cycle
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            portDOut <= KWU_DATA_RESET;
        end else begin
            portDOut <= portDData;
        end
    end

    // Unmapped port D floats its pins so the bus owner can drive them
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            portDOe <= KWU_DIR_RESET;
        end else begin
            portDOe <= portDMapped ? portDDir : KWU_DIR_RESET;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            portHOut <= KWU_DATA_RESET;
        end else begin
            portHOut <= portHData;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            portHOe <= KWU_DIR_RESET;
        end else begin
            portHOe <= portHDir;
        end
    end

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    always_comb begin
        next_portDIrq = extIntEnable && |(portDFlags & portDEnable);
        next_portHIrq = |(portHFlags & portHEnable);
    end

    // One line per port carries all eight pins
    // Registered for clean levels, at the cost of one cycle of latency
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            portDIrq <= 1'h0;
        end else begin
            portDIrq <= next_portDIrq;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            portHIrq <= 1'h0;
        end else begin
            portHIrq <= next_portHIrq;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            wakeIrq <= 1'h0;
        end else begin
            wakeIrq <= next_portDIrq || next_portHIrq;
        end
    end

    // Stop-mode wake is combinational: with the clock stopped no flag
    // can set, so a low level on an enabled pin must reach the CPU
    // directly (on port D only while extIntEnable is set). Pins idle high; a level that is low on entry to stop
    // wakes at once, which software avoids by clearing that pin's enable bit first.
    always_comb begin
        stopWake = stopMode && (
            (extIntEnable && |(portDEnable & ~portDIn)) ||
            |(portHEnable & ~portHIn));
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Unmapped offsets and the hidden port D registers read as zero
    always_comb begin
        next_regRdata = KWU_READ_IDLE;
        if (!regRead) begin
            next_regRdata = KWU_READ_IDLE;
        end else if (regAddr == KWU_PORT_D_PIN_DATA && portDMapped) begin
            next_regRdata = pinView(portDDir, portDData, portDIn);
        end else if (regAddr == KWU_PORT_D_DIRECTION && portDMapped) begin
            next_regRdata = portDDir;
        end else if (regAddr == KWU_PORT_D_WAKE_ENABLE && portDMapped) begin
            next_regRdata = portDEnable;
        end else if (regAddr == KWU_PORT_D_WAKE_FLAGS && portDMapped) begin
            next_regRdata = portDFlags;
        end else if (regAddr == KWU_PORT_H_PIN_DATA) begin
            next_regRdata = pinView(portHDir, portHData, portHIn);
        end else if (regAddr == KWU_PORT_H_DIRECTION) begin
            next_regRdata = portHDir;
        end else if (regAddr == KWU_PORT_H_WAKE_ENABLE) begin
            next_regRdata = portHEnable;
        end else if (regAddr == KWU_PORT_H_WAKE_FLAGS) begin
            next_regRdata = portHFlags;
        end else if (regAddr == KWU_WAKE_CONTROL) begin
            next_regRdata = KWU_CONTROL_MASK & {6'h00, extBusMode,
                                                extIntEnable};
        end
    end

    // Data stand only in the cycle after the read strobe
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            regRdata <= KWU_READ_IDLE;
        end else begin
            regRdata <= next_regRdata;
        end
    end

endmodule

// >>> core/kwu_pkg.sv
// Register map and reset values for the port D/H key wakeup block
package kwu_pkg;

    // ------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------
    localparam int KWU_ADDR_W = 4;
    localparam int KWU_DATA_W = 8;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [3:0] KWU_PORT_D_PIN_DATA = 4'h0;
    localparam logic [3:0] KWU_PORT_D_DIRECTION = 4'h1;
    localparam logic [3:0] KWU_PORT_D_WAKE_ENABLE = 4'h2;
    localparam logic [3:0] KWU_PORT_D_WAKE_FLAGS = 4'h3;
    localparam logic [3:0] KWU_PORT_H_PIN_DATA = 4'h4;
    localparam logic [3:0] KWU_PORT_H_DIRECTION = 4'h5;
    localparam logic [3:0] KWU_PORT_H_WAKE_ENABLE = 4'h6;
    localparam logic [3:0] KWU_PORT_H_WAKE_FLAGS = 4'h7;
    localparam logic [3:0] KWU_WAKE_CONTROL = 4'h8;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int KWU_EXT_INT_EN_BIT = 0;
    localparam int KWU_EXT_BUS_MODE_BIT = 1;
    localparam logic [7:0] KWU_CONTROL_MASK = 8'h03;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] KWU_DATA_RESET = 8'h00;
    localparam logic [7:0] KWU_DIR_RESET = 8'h00;
    localparam logic [7:0] KWU_ENABLE_RESET = 8'h00;
    localparam logic [7:0] KWU_FLAGS_RESET = 8'h00;
    localparam logic [7:0] KWU_CONTROL_RESET = 8'h00;
    localparam logic [7:0] KWU_PIN_HISTORY_RESET = 8'h00;
    localparam logic [7:0] KWU_READ_IDLE = 8'h00;

endpackage

// >>> sim/kwu_ports_sva.sv
// Assertion checker for the port D/H key wakeup block
`timescale 1ns/10ps
module kwu_ports_sva
    import kwu_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [KWU_ADDR_W-1:0] regAddr,
    input wire logic [KWU_DATA_W-1:0] regWdata,
    input wire logic regWrite,
    input wire logic [WIDTH-1:0] portDIn,
    input wire logic [WIDTH-1:0] portDOe,
    input wire logic [WIDTH-1:0] portHIn,
    input wire logic [WIDTH-1:0] portHOe,
    input wire logic stopMode,
    input wire logic portDIrq,
    input wire logic portHIrq,
    input wire logic wakeIrq,
    input wire logic stopWake
);
    // ------------------------------------------------------------
    // Sequences
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence wrDirH;
        regWrite && regAddr == KWU_PORT_H_DIRECTION;
    endsequence
    // Pin fell two edges ago: flag one edge later, request one more
    sequence fellH;
        |($past(portHIn, 3) & ~$past(portHIn, 2));
    endsequence
    sequence fellD;
        |($past(portDIn, 3) & ~$past(portDIn, 2));
    endsequence
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    AST_RST_CLEAR: assert property (disable iff (1'h0) !rst_n |=>
        !portDIrq && !portHIrq && portDOe == 0 && portHOe == 0)
        else $error("outputs not cleared by reset");
    AST_WAKE_MERGE: assert property (wakeIrq == (portDIrq || portHIrq))
        else $error("wake request differs from port requests");
    AST_STOP_GATE: assert property (!stopMode |-> !stopWake)
        else $error("stop wake outside stop mode");
    AST_OE_DIR_H: assert property (wrDirH |-> ##2
        portHOe == $past(regWdata, 2))
        else $error("port H enables do not follow direction");
    AST_EDGE_H: assert property ($rose(portHIrq) |->
        fellH or $past(regWrite, 2))
        else $error("port H request without falling edge");
    AST_EDGE_D: assert property ($rose(portDIrq) |->
        fellD or $past(regWrite, 2))
        else $error("port D request without falling edge");
    // A mid-run reset also drops the requests
    AST_HOLD_H: assert property ($fell(portHIrq) |->
        $past(regWrite, 2) || !$past(rst_n))
        else $error("port H request dropped without a write");
    AST_HOLD_D: assert property ($fell(portDIrq) |->
        $past(regWrite, 2) || !$past(rst_n))
        else $error("port D request dropped without a write");
endmodule

bind kwu_ports kwu_ports_sva #(.WIDTH(WIDTH)) sva (
    .clock(clock), .rst_n(rst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .portDIn(portDIn),
    .portDOe(portDOe), .portHIn(portHIn), .portHOe(portHOe),
    .stopMode(stopMode), .portDIrq(portDIrq), .portHIrq(portHIrq),
    .wakeIrq(wakeIrq), .stopWake(stopWake)
);

// >>> sim/kwu_pin_model.sv
// Pin-side model: push buttons to ground with pull-ups on ports D and H
`timescale 1ns/10ps
module kwu_pin_model (
    input wire logic [7:0] pressD,
    input wire logic [7:0] pressH,
    input wire logic [7:0] outD,
    input wire logic [7:0] oeD,
    input wire logic [7:0] outH,
    input wire logic [7:0] oeH,
    output logic [7:0] pinD,
    output logic [7:0] pinH
);
    // A driven pin shows its own level, so edges can come from outputs
    assign pinD = (oeD & outD) | (~oeD & ~pressD);
    assign pinH = (oeH & outH) | (~oeH & ~pressH);
endmodule

// >>> sim/kwu_ports_bench.sv
// Self-checking bench for the port D/H key wakeup block
`timescale 1ns/10ps
module kwu_ports_bench;
    import kwu_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic clock = 1'h0;
    logic rst_n = 1'h0;
    logic [3:0] regAddr = 4'h0;
    logic [7:0] regWdata = 8'h00;
    logic regWrite = 1'h0;
    logic regRead = 1'h0;
    logic wideExpandedMode = 1'h0;
    logic specialNarrowMode = 1'h0;
    logic stopMode = 1'h0;
    logic [7:0] pressD = 8'h00;
    logic [7:0] pressH = 8'h00;
    logic [7:0] regRdata, portDIn, portDOut, portDOe;
    logic [7:0] portHIn, portHOut, portHOe;
    logic portDIrq, portHIrq, wakeIrq, stopWake;
    logic [7:0] expQ[$];
    logic rdSeen = 1'h0;
    logic [15:0] seed = 16'hb9ea;
    logic [7:0] v;
    int num_errors = 0;
    int checked = 0;
    always #2.5 clock = ~clock;
    kwu_ports uut (
        .clock(clock), .rst_n(rst_n), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
        .regRdata(regRdata), .portDIn(portDIn), .portDOut(portDOut),
        .portDOe(portDOe), .portHIn(portHIn), .portHOut(portHOut),
        .portHOe(portHOe), .wideExpandedMode(wideExpandedMode),
        .specialNarrowMode(specialNarrowMode), .stopMode(stopMode),
        .portDIrq(portDIrq), .portHIrq(portHIrq), .wakeIrq(wakeIrq),
        .stopWake(stopWake)
    );
    kwu_pin_model pins (
        .pressD(pressD), .pressH(pressH), .outD(portDOut), .oeD(portDOe),
        .outH(portHOut), .oeH(portHOe), .pinD(portDIn), .pinH(portHIn)
    );
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'h1;
        @(posedge clock);
        regWrite <= 1'h0;
    endtask
    task rd(input logic [3:0] a, input logic [7:0] e);
        expQ.push_back(e);
        @(posedge clock);
        regAddr <= a;
        regRead <= 1'h1;
        @(posedge clock);
        regRead <= 1'h0;
    endtask
    // Waits past the edge so that its updates have landed
    task tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task complete_run;
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Read data stand only in the cycle after the strobe
    always @(posedge clock) begin
        if (rdSeen) chk(regRdata, expQ.pop_front());
        rdSeen <= regRead;
    end
    initial begin
        #50000;
        num_errors++;
        complete_run;
    end
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clock);
        rst_n <= 1'h1;
        for (int a = 0; a < 16; a++) begin
            // Input pins read their pulled-up level, not the latch
            if (a == 0 || a == 4) rd(4'(a), 8'hff);
            else if (a < 9 || a == 15) rd(4'(a), 8'h00);
        end
        $display("test reset done");
        wr(KWU_PORT_H_WAKE_ENABLE, 8'h01);
        @(posedge clock) pressH <= 8'h01;
        tick(3);
        chk({7'h00, portHIrq}, 8'h01);
        chk({7'h00, wakeIrq}, 8'h01);
        wr(KWU_PORT_H_WAKE_FLAGS, 8'h00);
        rd(KWU_PORT_H_WAKE_FLAGS, 8'h01);
        wr(KWU_PORT_H_WAKE_ENABLE, 8'h00);
        tick(2);
        chk({7'h00, portHIrq}, 8'h00);
        wr(KWU_PORT_H_WAKE_ENABLE, 8'h01);
        wr(KWU_PORT_H_WAKE_FLAGS, 8'h01);
        tick(2);
        chk({7'h00, portHIrq}, 8'h00);
        @(posedge clock) pressH <= 8'h00;
        tick(3);
        rd(KWU_PORT_H_WAKE_FLAGS, 8'h00);
        $display("test port H edge done");
        wr(KWU_PORT_H_DIRECTION, 8'hff);
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            v = seed[7:0] | 8'h80;
            wr(KWU_PORT_H_PIN_DATA, v);
            tick(4);
            wr(KWU_PORT_H_WAKE_FLAGS, 8'hff);
            wr(KWU_PORT_H_PIN_DATA, v & 8'h7f);
            tick(4);
            rd(KWU_PORT_H_WAKE_FLAGS, 8'h80);
            rd(KWU_PORT_H_PIN_DATA, v & 8'h7f);
            chk(portHOe, 8'hff);
            chk(portHOut, v & 8'h7f);
        end
        $display("test output edge done");
        // Port H outputs still drive lows that would wake from stop
        wr(KWU_PORT_H_WAKE_ENABLE, 8'h00);
        wr(KWU_PORT_D_WAKE_ENABLE, 8'h08);
        @(posedge clock) pressD <= 8'h08;
        stopMode <= 1'h1;
        tick(3);
        chk({7'h00, portDIrq}, 8'h00);
        chk({7'h00, stopWake}, 8'h00);
        wr(KWU_WAKE_CONTROL, 8'h01);
        tick(2);
        chk({7'h00, portDIrq}, 8'h01);
        chk({7'h00, stopWake}, 8'h01);
        @(posedge clock) stopMode <= 1'h0;
        tick(1);
        chk({7'h00, stopWake}, 8'h00);
        wr(KWU_PORT_D_WAKE_FLAGS, 8'h08);
        pressD <= 8'h00;
        tick(3);
        chk({7'h00, portDIrq}, 8'h00);
        $display("test port D gate done");
        wr(KWU_PORT_D_DIRECTION, 8'h5a);
        @(posedge clock) wideExpandedMode <= 1'h1;
        rd(KWU_PORT_D_DIRECTION, 8'h00);
        wr(KWU_PORT_D_DIRECTION, 8'hff);
        tick(2);
        chk(portDOe, 8'h00);
        @(posedge clock) wideExpandedMode <= 1'h0;
        wr(KWU_WAKE_CONTROL, 8'h03);
        specialNarrowMode <= 1'h1;
        rd(KWU_PORT_D_DIRECTION, 8'h00);
        specialNarrowMode <= 1'h0;
        rd(KWU_PORT_D_DIRECTION, 8'h5a);
        tick(3);
        chk({7'h00, portDIrq}, 8'h01);
        $display("test unmap done");
        @(posedge clock) rst_n <= 1'h0;
        repeat (3) @(posedge clock);
        rst_n <= 1'h1;
        chk({7'h00, portDIrq}, 8'h00);
        chk(portDOe, 8'h00);
        rd(KWU_PORT_D_WAKE_FLAGS, 8'h00);
        rd(KWU_WAKE_CONTROL, 8'h00);
        wr(KWU_PORT_D_PIN_DATA, 8'h3c);
        tick(2);
        chk(portDOut, 8'h3c);
        tick(1);
        $display("test mid-run reset done");
        complete_run;
    end
endmodule
